// File: frontend_model.sv
`timescale 1ns/100ps
// ------------------------------
// frontend units and boot memory
// ------------------------------
module frontend_model
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic [4:0][31:0] boot_words,
   input wire logic [2:0] firmware_data_area_two_addr,
   output logic [31:0] firmware_data_area_two_data,
   input wire rate_sched_pkg::task_launch_t task_launch,
   input wire logic post_start,
   output logic meas_done,
   output logic post_done,
   output logic [1:0] frontend_status_flags
);
   int meas_wait;
   int post_wait;
   logic [1:0] pend_flags;
   always @(posedge ref_clk)
   begin
      firmware_data_area_two_data <= (firmware_data_area_two_addr < 3'h5) ? boot_words[firmware_data_area_two_addr] : 32'h0;
      meas_done <= 1'b0;
      post_done <= 1'b0;
      if (reset)
      begin
         meas_wait <= 0;
         post_wait <= 0;
         frontend_status_flags <= 2'h0;
      end
      else
      begin
         if (meas_wait > 0)
            meas_wait <= meas_wait - 1;
         if (meas_wait == 1)
         begin
            meas_done <= 1'b1;
            frontend_status_flags <= pend_flags;
         end
         if (|task_launch)
         begin
            meas_wait <= slow ? 200 : 10;
            pend_flags <= {task_launch.temperature, task_launch.flight_time};
         end
         if (post_wait > 0)
            post_wait <= post_wait - 1;
         if (post_wait == 1)
            post_done <= 1'b1;
         if (post_start)
            post_wait <= 5;
      end
   end
endmodule

// File: measure_rate_task_scheduler.sv
`timescale 1ns/100ps
`include "rate_sched_cfg.svh"
// Behaviour
// - cycle period equals cycle_period_field times 976.5625 us, field 0..8191
// - two alternating trigger channels: A flow and amplitude, B the rest
// - channel B triggers half a cycle after channel A
// - temperature runs every temp_meas_interval triggers, zero disables
// - amplitude runs every coded 1..100 triggers, code zero disables
// - amplitude calibration runs every coded N amplitude measurements
// - flight time runs every flight_time_interval triggers, zero disables
// - fast clock calibration runs every coded N triggers, zero disables
// - supply check runs every coded N triggers, zero disables
// - slow oscillator drives cycle, pulse base, time stamp and 4800 baud tick
// - fast oscillator and analog parts enabled only while measuring
// - boot copies firmware_data_area_two words into the configuration registers
// - in self-controlled modes a trigger that selects a task starts the task_sequencer when idle
// - remote mode: host launches tasks, no rate generation or post-processing
// - self-controlled time conversion mode skips post-processing
// - post-processing picks flow or temperature from frontend_status_flags
// - when enabled and not in remote mode, a wake-up request goes to the external controller
module measure_rate_task_scheduler
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic slow_osc_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic [2:0] firmware_data_area_two_addr,
   input wire logic [31:0] firmware_data_area_two_data,
   input wire logic meas_done,
   input wire logic post_done,
   input wire logic [1:0] frontend_status_flags,
   output rate_sched_pkg::task_launch_t task_launch,
   output logic fast_osc_enable,
   output logic analog_enable,
   output logic post_start,
   output logic post_select_temp,
   output logic wake_request,
   output logic baud_tick,
   output logic lso_tick,
   output logic [31:0] time_stamp
);

   localparam int unsigned CYCLE_TICKS = int'(`CYCLE_UNIT_US * `SLOW_OSC_HZ / 1.0e6);
   localparam logic [17:0] CYCLE_TICKS_W = 18'(CYCLE_TICKS);
   localparam logic [15:0] BAUD_STEP = 16'(`BAUD_RATE);
   localparam logic [16:0] BAUD_WRAP = 17'(`SLOW_OSC_HZ);

   rate_sched_pkg::sched_state_t s;
   rate_sched_pkg::sched_state_t n;

   // ----------------------------------------------------
   // coded interval: 0 off, then 1, 2, 5, 10, 20, 50, 100
   // ----------------------------------------------------
   function automatic logic [9:0] coded_interval(input logic [2:0] code);
      logic [9:0] r;
      unique case (code)
         3'h0: r = 10'h000;
         3'h1: r = 10'h001;
         3'h2: r = 10'h002;
         3'h3: r = 10'h005;
         3'h4: r = 10'h00a;
         3'h5: r = 10'h014;
         3'h6: r = 10'h032;
         3'h7: r = 10'h064;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------
   // one trigger into an interval counter: {fire, next count}
   // ----------------------------------------------------
   function automatic logic [10:0] interval_step(input logic [9:0] cnt, input logic [9:0] limit);
      logic [9:0] inc;
      inc = cnt + 10'h001;
      if (limit == 10'h000)
         return {1'b0, 10'h000};
      else if (inc >= limit)
         return {1'b1, 10'h000};
      else
         return {1'b0, inc};
   endfunction

   logic tick;
   logic remote_mode;
   logic [1:0] mode;
   logic [12:0] cycle_field;
   logic [17:0] period;
   logic [17:0] half;
   logic [17:0] cnt1;
   logic trig_a;
   logic trig_b;
   logic [16:0] baud_sum;
   logic [10:0] step;
   rate_sched_pkg::task_launch_t want;

   always_comb
   begin
      n = s;
      tick = 1'b0;
      remote_mode = 1'b0;
      mode = 2'h0;
      cycle_field = 13'h0000;
      period = 18'h00000;
      half = 18'h00000;
      cnt1 = 18'h00000;
      trig_a = 1'b0;
      trig_b = 1'b0;
      baud_sum = 17'h00000;
      step = 11'h000;
      want = '0;
      n.launch = '0;
      n.post_start = 1'b0;
      n.wake_req = 1'b0;
      n.baud_tick = 1'b0;

      // ----------------------------------------------------
      // slow oscillator sampled into this domain
      // ----------------------------------------------------
      n.lso_sync = {s.lso_sync[0], slow_osc_pin};
      n.lso_prev = s.lso_sync[1];
      tick = s.lso_sync[1] & ~s.lso_prev;

      mode = s.cycle_rate_config[`MODE_LSB +: 2];
      remote_mode = mode[1];
      cycle_field = s.cycle_rate_config[`CYCLE_FIELD_LSB +: 13];
      period = 18'(cycle_field * CYCLE_TICKS_W);
      half = period >> 1;

      // ----------------------------------------------------
      // cycle timer with the two channels
      // ----------------------------------------------------
      if (remote_mode || cycle_field == 13'h0000 || s.seq == rate_sched_pkg::SEQ_BOOT)
         n.cyc_cnt = 18'h00000;
      else if (tick)
      begin
         cnt1 = s.cyc_cnt + 18'h00001;
         if (cnt1 >= period)
         begin
            n.cyc_cnt = 18'h00000;
            trig_a = 1'b1;
         end
         else
         begin
            n.cyc_cnt = cnt1;
            trig_b = (cnt1 == half);
         end
      end

      // ----------------------------------------------------
      // baud tick and time stamp from the slow clock
      // ----------------------------------------------------
      if (tick)
      begin
         n.stamp = s.stamp + 32'h00000001;
         baud_sum = {1'b0, s.baud_acc} + {1'b0, BAUD_STEP};
         if (baud_sum >= BAUD_WRAP)
         begin
            n.baud_acc = 16'(baud_sum - BAUD_WRAP);
            n.baud_tick = 1'b1;
         end
         else
            n.baud_acc = baud_sum[15:0];
      end

      // ----------------------------------------------------
      // channel A task dividers
      // ----------------------------------------------------
      if (trig_a)
      begin
         step = interval_step(s.flight_cnt, {4'h0, s.flight_time_rate[`FLIGHT_LSB +: 6]});
         want.flight_time = step[10];
         n.flight_cnt = step[9:0];
         step = interval_step(s.amp_cnt, coded_interval(s.amplitude_config[`AMP_MEAS_LSB +: 3]));
         want.amplitude = step[10];
         n.amp_cnt = step[9:0];
         if (want.amplitude)
         begin
            step = interval_step(s.amp_cal_cnt, coded_interval(s.amplitude_config[`AMP_CAL_LSB +: 3]));
            want.amp_cal = step[10];
            n.amp_cal_cnt = step[9:0];
         end
      end

      // ----------------------------------------------------
      // channel B task dividers
      // ----------------------------------------------------
      if (trig_b)
      begin
         step = interval_step(s.temp_cnt, s.temperature_rate_config[`TEMP_LSB +: 10]);
         want.temperature = step[10];
         n.temp_cnt = step[9:0];
         step = interval_step(s.supply_cnt, coded_interval(s.clock_power_config[`SUPPLY_LSB +: 3]));
         want.supply = step[10];
         n.supply_cnt = step[9:0];
         step = interval_step(s.fast_cal_cnt, coded_interval(s.clock_power_config[`FAST_CAL_LSB +: 3]));
         want.fast_clock_cal = step[10];
         n.fast_cal_cnt = step[9:0];
         want.offset_cal = 1'b1;
      end

      // ----------------------------------------------------
      // remote launches come straight from the host
      // ----------------------------------------------------
      if (remote_mode && reg_write && reg_addr == `OFS_REMOTE_TASK)
         want = rate_sched_pkg::task_launch_t'(reg_wdata[6:0]);

      // ----------------------------------------------------
      // task sequencer
      // ----------------------------------------------------
      unique case (s.seq)
         rate_sched_pkg::SEQ_BOOT:
         begin
            if (s.boot_idx != 3'h0)
            begin
               unique case (s.boot_idx)
                  3'h1: n.clock_power_config = firmware_data_area_two_data;
                  3'h2: n.cycle_rate_config = firmware_data_area_two_data;
                  3'h3: n.temperature_rate_config = firmware_data_area_two_data;
                  3'h4: n.amplitude_config = firmware_data_area_two_data;
                  default: n.flight_time_rate = firmware_data_area_two_data;
               endcase
            end
            if (s.boot_idx == `BOOT_WORDS)
               n.seq = rate_sched_pkg::SEQ_IDLE;
            else
               n.boot_idx = s.boot_idx + 3'h1;
         end
         rate_sched_pkg::SEQ_IDLE:
         begin
            if (want != '0)
            begin
               n.launch = want;
               n.seq = rate_sched_pkg::SEQ_MEASURE;
            end
         end
         rate_sched_pkg::SEQ_MEASURE:
         begin
            if (meas_done)
            begin
               if (!remote_mode && mode == `MODE_FLOW_METER && s.cycle_rate_config[`POST_EN_BIT])
               begin
                  n.post_start = 1'b1;
                  n.post_temp = frontend_status_flags[`FLAG_TEMP_BIT] & ~frontend_status_flags[`FLAG_FLOW_BIT];
                  n.seq = rate_sched_pkg::SEQ_POST;
               end
               else
                  n.seq = rate_sched_pkg::SEQ_WAKE;
            end
         end
         rate_sched_pkg::SEQ_POST:
         begin
            if (post_done)
               n.seq = rate_sched_pkg::SEQ_WAKE;
         end
         rate_sched_pkg::SEQ_WAKE:
         begin
            n.wake_req = s.cycle_rate_config[`WAKE_EN_BIT] & ~remote_mode;
            n.seq = rate_sched_pkg::SEQ_IDLE;
         end
      endcase

      // ----------------------------------------------------
      // register writes
      // ----------------------------------------------------
      if (reg_write)
      begin
         unique case (reg_addr)
            `OFS_CLOCK_POWER: n.clock_power_config = reg_wdata;
            `OFS_CYCLE_RATE: n.cycle_rate_config = reg_wdata;
            `OFS_TEMP_RATE: n.temperature_rate_config = reg_wdata;
            `OFS_AMPLITUDE: n.amplitude_config = reg_wdata;
            `OFS_FLIGHT_TIME: n.flight_time_rate = reg_wdata;
            `OFS_SCHED_STATUS:
               if (reg_wdata[`STAT_OVERRUN_BIT])
                  n.overrun = 1'b0;
            default: ;
         endcase
      end

      // ----------------------------------------------------
      // a trigger lost while busy sets overrun; set wins over clear
      // ----------------------------------------------------
      if (want != '0 && s.seq != rate_sched_pkg::SEQ_IDLE)
         n.overrun = 1'b1;

      // ----------------------------------------------------
      // register reads, data in the following cycle
      // ----------------------------------------------------
      n.rdata = 32'h00000000;
      if (reg_read)
      begin
         unique case (reg_addr)
            `OFS_CLOCK_POWER: n.rdata = s.clock_power_config;
            `OFS_CYCLE_RATE: n.rdata = s.cycle_rate_config;
            `OFS_TEMP_RATE: n.rdata = s.temperature_rate_config;
            `OFS_AMPLITUDE: n.rdata = s.amplitude_config;
            `OFS_FLIGHT_TIME: n.rdata = s.flight_time_rate;
            `OFS_SCHED_STATUS:
            begin
               n.rdata[`STAT_OVERRUN_BIT] = s.overrun;
               n.rdata[`STAT_BOOT_BIT] = (s.seq == rate_sched_pkg::SEQ_BOOT);
               n.rdata[`STAT_BUSY_BIT] = (s.seq != rate_sched_pkg::SEQ_IDLE);
            end
            `OFS_TIME_STAMP: n.rdata = s.stamp;
            default: n.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s <= '0;
         s.seq <= rate_sched_pkg::SEQ_BOOT;
         s.clock_power_config <= `CFG_RESET;
         s.cycle_rate_config <= `CFG_RESET;
         s.temperature_rate_config <= `CFG_RESET;
         s.amplitude_config <= `CFG_RESET;
         s.flight_time_rate <= `CFG_RESET;
      end
      else
         s <= n;
   end

   assign reg_rdata = s.rdata;
   assign firmware_data_area_two_addr = s.boot_idx;
   assign task_launch = s.launch;
   assign fast_osc_enable = (s.seq == rate_sched_pkg::SEQ_MEASURE);
   assign analog_enable = (s.seq == rate_sched_pkg::SEQ_MEASURE);
   assign post_start = s.post_start;
   assign post_select_temp = s.post_temp;
   assign wake_request = s.wake_req;
   assign baud_tick = s.baud_tick;
   assign lso_tick = tick;
   assign time_stamp = s.stamp;

   // ----------------------------------------------------
   // assertions
   // ----------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   cycle_wrap_a: assert property (trig_a |-> cnt1 == period && period != 18'h00000 ##1 s.cyc_cnt == 18'h00000)
      else $error("channel A fired off the cycle boundary");

   half_cycle_a: assert property (trig_b |-> s.cyc_cnt + 18'h00001 == half && !trig_a)
      else $error("channel B not at half cycle");

   remote_quiet_a: assert property (remote_mode |-> !trig_a && !trig_b && !n.post_start)
      else $error("internal rate or post activity in remote mode");

   conv_no_post_a: assert property (mode == `MODE_TIME_CONV |-> !n.post_start)
      else $error("post-processing in time conversion mode");

   launch_analog_a: assert property (s.seq == rate_sched_pkg::SEQ_IDLE && want != '0 |=> task_launch == $past(want)
      && fast_osc_enable && analog_enable)
      else $error("launch without analog power");

   analog_off_a: assert property (s.seq != rate_sched_pkg::SEQ_MEASURE |-> !fast_osc_enable && !analog_enable)
      else $error("analog powered outside measurement");

   temp_off_a: assert property (s.temperature_rate_config[9:0] == 10'h000 && !remote_mode |-> !want.temperature)
      else $error("temperature launched while disabled");

   flight_off_a: assert property (s.flight_time_rate[5:0] == 6'h00 && !remote_mode |-> !want.flight_time)
      else $error("flight time launched while disabled");

   amp_cal_only_a: assert property (want.amp_cal && !remote_mode |-> want.amplitude)
      else $error("amplitude calibration without amplitude measurement");

   boot_no_trig_a: assert property (s.seq == rate_sched_pkg::SEQ_BOOT |-> !trig_a && !trig_b ##1 task_launch == '0)
      else $error("trigger during boot copy");

   post_pick_a: assert property (s.seq == rate_sched_pkg::SEQ_MEASURE && meas_done && n.post_start |=>
      post_select_temp == ($past(frontend_status_flags[1]) && !$past(frontend_status_flags[0])))
      else $error("post selection does not follow status flags");

endmodule

// File: rate_sched_cfg.svh
`ifndef RATE_SCHED_CFG_SVH
`define RATE_SCHED_CFG_SVH

// register offsets
`define OFS_CLOCK_POWER 8'hc5
`define OFS_CYCLE_RATE 8'hc6
`define OFS_TEMP_RATE 8'hc7
`define OFS_AMPLITUDE 8'hcb
`define OFS_FLIGHT_TIME 8'hd0
`define OFS_SCHED_STATUS 8'he0
`define OFS_REMOTE_TASK 8'he1
`define OFS_TIME_STAMP 8'he2

// clock_power_config fields
`define FAST_CAL_LSB 0
`define SUPPLY_LSB 4
// cycle_rate_config fields
`define CYCLE_FIELD_LSB 0
`define POST_EN_BIT 16
`define MODE_LSB 17
`define WAKE_EN_BIT 19
// temperature_rate_config, amplitude_config, flight_time_rate fields
`define TEMP_LSB 0
`define AMP_MEAS_LSB 0
`define AMP_CAL_LSB 4
`define FLIGHT_LSB 0
// status fields
`define STAT_OVERRUN_BIT 0
`define STAT_BOOT_BIT 1
`define STAT_BUSY_BIT 2

// conversion modes
`define MODE_FLOW_METER 2'h0
`define MODE_TIME_CONV 2'h1

// frontend status flag positions
`define FLAG_FLOW_BIT 0
`define FLAG_TEMP_BIT 1

// boot copy
`define BOOT_WORDS 3'h5
`define CFG_RESET 32'h0

// timing
`define CYCLE_UNIT_US 976.5625
`define SLOW_OSC_HZ 32768
`define BAUD_RATE 4800

`endif

// File: rate_sched_pkg.sv
package rate_sched_pkg;

   typedef enum logic [2:0] {SEQ_BOOT, SEQ_IDLE, SEQ_MEASURE, SEQ_POST, SEQ_WAKE} seq_state_t;

   typedef struct packed {
      logic flight_time;
      logic amplitude;
      logic amp_cal;
      logic temperature;
      logic supply;
      logic fast_clock_cal;
      logic offset_cal;
   } task_launch_t;

   typedef struct packed {
      logic [1:0] lso_sync;
      logic lso_prev;
      logic [31:0] clock_power_config;
      logic [31:0] cycle_rate_config;
      logic [31:0] temperature_rate_config;
      logic [31:0] amplitude_config;
      logic [31:0] flight_time_rate;
      logic [17:0] cyc_cnt;
      logic [9:0] flight_cnt;
      logic [9:0] amp_cnt;
      logic [9:0] amp_cal_cnt;
      logic [9:0] temp_cnt;
      logic [9:0] supply_cnt;
      logic [9:0] fast_cal_cnt;
      logic [15:0] baud_acc;
      logic [31:0] stamp;
      seq_state_t seq;
      logic [2:0] boot_idx;
      task_launch_t launch;
      logic post_start;
      logic post_temp;
      logic wake_req;
      logic baud_tick;
      logic overrun;
      logic [31:0] rdata;
   } sched_state_t;

endpackage

// File: tb.sv
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic slow_osc_pin = 1'b0;
   logic slow = 1'b0;
   logic [2:0] div = 3'h0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata, firmware_data_area_two_data, time_stamp, d, t0;
   logic [2:0] firmware_data_area_two_addr;
   logic [1:0] flags;
   logic [6:0] last_launch;
   logic meas_done, post_done, fast_osc_enable, analog_enable, post_start, post_select_temp;
   logic wake_request, baud_tick, lso_tick;
   rate_sched_pkg::task_launch_t task_launch;
   logic [4:0][31:0] boot = {32'h1, 32'h21, 32'h3, 32'h0009_0001, 32'h21};
   logic [4:0][7:0] ofs = {8'hd0, 8'hcb, 8'hc7, 8'hc6, 8'hc5};
   int e1 [7] = '{6, 6, 3, 2, 3, 6, 6};
   int e2 [7] = '{4, 4, 2, 0, 0, 0, 2};
   int cnt [7];
   int n_launch, n_post, n_wake, n_lso, n_baud, a_gap, b_off, t_a, cyc, i, k, mi;
   int n_errors = 0;
   int check_count = 0;

   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      div <= div + 3'h1;
      slow_osc_pin <= div[2];
   end

   measure_rate_task_scheduler uut (.ref_clk(ref_clk), .reset(reset), .slow_osc_pin(slow_osc_pin),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .firmware_data_area_two_addr(firmware_data_area_two_addr), .firmware_data_area_two_data(firmware_data_area_two_data), .meas_done(meas_done),
      .post_done(post_done), .frontend_status_flags(flags), .task_launch(task_launch),
      .fast_osc_enable(fast_osc_enable), .analog_enable(analog_enable), .post_start(post_start),
      .post_select_temp(post_select_temp), .wake_request(wake_request), .baud_tick(baud_tick),
      .lso_tick(lso_tick), .time_stamp(time_stamp));
   frontend_model partner (.ref_clk(ref_clk), .reset(reset), .slow(slow), .boot_words(boot),
      .firmware_data_area_two_addr(firmware_data_area_two_addr), .firmware_data_area_two_data(firmware_data_area_two_data), .task_launch(task_launch), .post_start(post_start),
      .meas_done(meas_done), .post_done(post_done), .frontend_status_flags(flags));

   // ----------------
   // checks and tasks
   // ----------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      v = reg_rdata;
   endtask

   task wait_on(input int idx, input int n);
      for (k = 0; k < 4000 && cnt[idx] < n; k++)
         @(posedge ref_clk);
      if (cnt[idx] < n)
      begin
         n_errors++;
         $display("BAD %0t wait expired", $time);
         end_sim();
      end
   endtask

   task clr_counts;
      foreach (cnt[j])
         cnt[j] = 0;
      n_launch = 0;
      n_post = 0;
      n_wake = 0;
   endtask

   task sync_b;
      wait_on(0, cnt[0] + 1);
      @(negedge ref_clk);
      clr_counts();
   endtask

   task end_sim;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -------------------
   // output monitor
   // -------------------
   always @(posedge ref_clk)
   begin
      cyc++;
      n_lso += lso_tick;
      n_baud += baud_tick;
      if (!reset && |task_launch)
      begin
         for (mi = 0; mi < 7; mi++)
            cnt[mi] += task_launch[mi];
         n_launch++;
         last_launch = task_launch;
         chk(fast_osc_enable & analog_enable, 1'b1);
         chk((|task_launch[6:4]) & (|task_launch[3:0]), 1'b0);
         if (task_launch.flight_time)
         begin
            a_gap = cyc - t_a;
            t_a = cyc;
         end
         if (task_launch.offset_cal)
            b_off = cyc - t_a;
      end
      if (!reset && post_start)
      begin
         n_post++;
         chk(post_select_temp, flags[1] & ~flags[0]);
      end
      if (!reset && wake_request)
         n_wake++;
   end

   // -------------------
   // main sequence
   // -------------------
   initial
   begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      d = 32'h2;
      for (i = 0; i < 50 && d[1] !== 1'b0; i++)
         rd(8'he0, d);
      chk(d[1], 1'b0);
      for (i = 0; i < 5; i++)
      begin
         rd(ofs[i], d);
         chk(d, boot[i]);
      end
      wait_on(6, 6);
      repeat (100) @(posedge ref_clk);
      for (i = 0; i < 7; i++)
         chk(cnt[i], e1[i]);
      chk(a_gap, 256);
      chk(b_off, 128);
      chk(n_launch, 12);
      chk(n_post, 12);
      chk(n_wake, 12);
      wr(8'hc7, 32'h0);
      wr(8'hcb, 32'h0);
      wr(8'hd0, 32'h2);
      rd(8'hd0, d);
      chk(d, 32'h2);
      rd(8'hff, d);
      chk(d, 32'h0);
      sync_b();
      wait_on(0, 4);
      for (i = 0; i < 7; i++)
         chk(cnt[i], e2[i]);
      wr(8'hc6, 32'h000b_0001);
      sync_b();
      wait_on(0, 2);
      repeat (50) @(posedge ref_clk);
      chk(n_post, 0);
      chk(n_wake, 4);
      slow <= 1'b1;
      repeat (512) @(posedge ref_clk);
      slow <= 1'b0;
      repeat (512) @(posedge ref_clk);
      rd(8'he0, d);
      chk(d[0], 1'b1);
      wr(8'he0, 32'h1);
      rd(8'he0, d);
      chk(d[0], 1'b0);
      wr(8'hc6, 32'h000d_0001);
      // no triggers in remote mode: let a sequence in flight finish, then clear
      repeat (20) @(negedge ref_clk);
      clr_counts();
      repeat (600) @(posedge ref_clk);
      chk(n_launch, 0);
      wr(8'he1, 32'h60);
      repeat (40) @(posedge ref_clk);
      chk(n_launch, 1);
      chk(last_launch, 7'h60);
      chk(n_post + n_wake, 0);
      chk(fast_osc_enable | analog_enable, 1'b0);
      for (k = 0; k < 20 && lso_tick !== 1'b1; k++)
         @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      n_lso = 0;
      n_baud = 0;
      t0 = time_stamp;
      for (k = 0; k < 10000 && n_lso < 1024; k++)
         @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      chk(n_baud, 150);
      chk(time_stamp - t0, 1024);
      end_sim();
   end
endmodule
